// ===== rtl/pcc_pkg.sv
// Shared constants and carriers for the clock configuration block
package pcc_pkg;
  // ==========================================
  // Register map
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CTRL2 = 8'h01;
  localparam logic [7:0] ADDR_PLL_CFG = 8'h02;
  localparam logic [7:0] ADDR_CAL = 8'h03;
  localparam logic [7:0] ADDR_RAMP_FLOOR = 8'h04;
  // ==========================================
  // Field positions
  localparam int DIV_RST_BIT = 22;
  localparam int DIV_SEL_LO = 20;
  localparam int DBL_EN_BIT = 19;
  localparam int PLL_EN_BIT = 18;
  localparam int DIV_EN_BIT = 17;
  localparam int DBL_EDGE_BIT = 16;
  localparam int FBN_LO = 8;
  localparam int MAN_ICP_BIT = 6;
  localparam int ICP_LO = 3;
  localparam int LOCK_EN_BIT = 2;
  localparam int LOCK_SEL_LO = 0;
  localparam int LOCK_STAT_BIT = 24;
  localparam int RAMP_EN_BIT = 19;
  localparam int AUX_PD_BIT = 26;
  localparam int CALCLK_PD_BIT = 25;
  localparam int CAL_EN_BIT = 24;
  // ==========================================
  // Reset values and limits
  localparam logic [31:0] PLL_CFG_RESET = 32'h0000_1900;
  localparam logic [31:0] CTRL2_RESET = 32'h0000_0800;
  localparam logic [7:0] FBN_RESET = 8'h19;
  localparam logic [7:0] FBN_MIN = 8'h0A;
  localparam logic [10:0] LOCK_BASE = 11'h080;
  // ==========================================
  // Carriers
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } pcc_req_t;

  typedef struct packed {
    logic div_active;
    logic [1:0] div_sel;
    logic doubler_on;
    logic pll_on;
    logic [8:0] mult;
    logic pump_manual;
    logic [2:0] pump_current;
    logic lock_det_on;
    logic sync_out_on;
    logic cal_clk_on;
    logic ramp_on;
  } pcc_ctrl_t;
endpackage

// ===== rtl/pcc_ref_divider.sv
// Reference input divider producing a divided-rate enable pulse
`timescale 1ns/1ps
`default_nettype none
module pcc_ref_divider
  import pcc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Control
  input wire logic div_rst,
  input wire logic div_en,
  input wire logic [1:0] div_sel,
  // Divided reference enable
  output logic ref_tick
);
  logic [2:0] cnt_q;
  wire logic [2:0] last_w = 3'((4'h1 << div_sel) - 4'h1);
  wire logic wrap_w = (cnt_q == last_w);

  // Bypass or a reset pulse gives one tick per cycle and restarts the count
  always_ff @(posedge ref_clk) begin
    if (rst || div_rst || !div_en) begin
      cnt_q <= 3'h0;
      ref_tick <= 1'b1;
    end else begin
      cnt_q <= wrap_w ? 3'h0 : cnt_q + 3'h1;
      ref_tick <= wrap_w;
    end
  end
endmodule // pcc_ref_divider
`default_nettype wire

// ===== rtl/pcc_lock_detect.sv
// Lock detector counting in-window reference cycles
`timescale 1ns/1ps
`default_nettype none
module pcc_lock_detect
  import pcc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Control and status
  input wire logic enable,
  input wire logic in_window,
  input wire logic ref_tick,
  input wire logic [1:0] win_sel,
  output logic locked
);
  logic [10:0] cnt_q;
  wire logic [10:0] target_w = LOCK_BASE << win_sel;

  always_ff @(posedge ref_clk) begin
    if (rst || !enable || !in_window) begin
      cnt_q <= 11'h000;
      locked <= 1'b0;
    end else if (ref_tick && !locked) begin
      cnt_q <= cnt_q + 11'h001;
      locked <= (cnt_q == target_w - 11'h001);
    end
  end
endmodule // pcc_lock_detect
`default_nettype wire

// ===== rtl/pcc_clock_config.sv
// Reference clock path configuration registers and control outputs
//
// How it works
// - Writing one to bit 22 pulses a reset of the input divider.
// - Bits 21:20 select reference division by 1, 2, 4 or 8.
// - Division applies only with bit 17 set; otherwise divider is bypassed.
// - Doubler runs only when bits 19 and 16 are both one.
// - Bit 18 enables the PLL, which then supplies the system clock.
// - Feedback field N at bits 15:8; total multiplication is 2N.
// - N valid from 10 to 255; resets to 25, multiplying by 50.
// - Bit 6 clear: automatic pump current; set: current from bits 5:3.
// - Bit 2 switches lock detection on or off.
// - Lock shown at 0x00 bit 24 after 128..1024 in-window cycles.
// - Bit 26 of the calibration register powers down sync output.
// - Calibration clock runs only with bits 25 and 26 both zero.
// - Writing one to bit 24 starts converter calibration.
// - Ramp lower limit matters only while ramp generator is enabled.
// - Bit 19 of second control register enables ramp generator.
`timescale 1ns/1ps
`default_nettype none
module pcc_clock_config
  import pcc_pkg::*;
#(
  parameter logic [31:0] CAL_RESET = 32'h0000_0000
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register port
  input wire pcc_req_t req,
  output logic [31:0] rdata,
  output logic rd_valid,
  // Analog-side pins
  input wire logic phase_in_window_pin,
  input wire logic [2:0] auto_pump_current_pin,
  // Control outputs
  output pcc_ctrl_t ctrl,
  output logic ref_tick,
  output logic locked,
  output logic div_reset,
  output logic cal_start,
  output logic [31:0] ramp_floor
);
  // ==========================================
  // Pin synchronisers
  logic win_s1_q, win_s2_q;
  logic [2:0] icp_s1_q, icp_s2_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      win_s1_q <= 1'b0;
      win_s2_q <= 1'b0;
      icp_s1_q <= 3'h0;
      icp_s2_q <= 3'h0;
    end else begin
      win_s1_q <= phase_in_window_pin;
      win_s2_q <= win_s1_q;
      icp_s1_q <= auto_pump_current_pin;
      icp_s2_q <= icp_s1_q;
    end
  end

  // ==========================================
  // Register decode
  logic [31:0] ctrl2_q, cfg_q, cal_q, floor_q;
  wire logic wr_ctrl2 = req.wr && (req.addr == ADDR_CTRL2);
  wire logic wr_cfg = req.wr && (req.addr == ADDR_PLL_CFG);
  wire logic wr_cal = req.wr && (req.addr == ADDR_CAL);
  wire logic wr_floor = req.wr && (req.addr == ADDR_RAMP_FLOOR);
  wire logic [31:0] status_w = 32'(locked) << LOCK_STAT_BIT;
  // Calibration start reads back as zero: it is a one-shot command
  wire logic [31:0] cal_rd_w = cal_q & ~(32'h1 << CAL_EN_BIT);
  wire logic [31:0] rd_mux_w =
    (req.addr == ADDR_STATUS) ? status_w :
    (req.addr == ADDR_CTRL2) ? ctrl2_q :
    (req.addr == ADDR_PLL_CFG) ? cfg_q :
    (req.addr == ADDR_CAL) ? cal_rd_w :
    (req.addr == ADDR_RAMP_FLOOR) ? floor_q : 32'h0000_0000;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl2_q <= CTRL2_RESET;
      cfg_q <= PLL_CFG_RESET;
      cal_q <= CAL_RESET;
      floor_q <= 32'h0000_0000;
    end else begin
      if (wr_ctrl2) ctrl2_q <= req.wdata;
      if (wr_cfg) cfg_q <= req.wdata;
      if (wr_cal) cal_q <= req.wdata;
      if (wr_floor) floor_q <= req.wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata <= 32'h0000_0000;
      rd_valid <= 1'b0;
    end else begin
      rdata <= req.rd ? rd_mux_w : rdata;
      rd_valid <= req.rd;
    end
  end

  // ==========================================
  // Command pulses
  wire logic div_rst_cmd = wr_cfg && req.wdata[DIV_RST_BIT];
  wire logic cal_cmd = wr_cal && req.wdata[CAL_EN_BIT];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      div_reset <= 1'b0;
      cal_start <= 1'b0;
    end else begin
      div_reset <= div_rst_cmd;
      cal_start <= cal_cmd;
    end
  end

  // ==========================================
  // Decoded control
  wire logic [7:0] fbn_w = cfg_q[FBN_LO +: 8];
  wire logic ramp_en_w = ctrl2_q[RAMP_EN_BIT];
  pcc_ctrl_t ctrl_d;

  always_comb begin
    ctrl_d.div_active = cfg_q[DIV_EN_BIT];
    ctrl_d.div_sel = cfg_q[DIV_SEL_LO +: 2];
    ctrl_d.doubler_on = cfg_q[DBL_EN_BIT] && cfg_q[DBL_EDGE_BIT];
    ctrl_d.pll_on = cfg_q[PLL_EN_BIT];
    ctrl_d.mult = {fbn_w, 1'b0};
    ctrl_d.pump_manual = cfg_q[MAN_ICP_BIT];
    ctrl_d.pump_current = cfg_q[MAN_ICP_BIT] ? cfg_q[ICP_LO +: 3] : icp_s2_q;
    ctrl_d.lock_det_on = cfg_q[LOCK_EN_BIT];
    ctrl_d.sync_out_on = !cal_q[AUX_PD_BIT];
    ctrl_d.cal_clk_on = !cal_q[CALCLK_PD_BIT] && !cal_q[AUX_PD_BIT];
    ctrl_d.ramp_on = ramp_en_w;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl <= '0;
      ramp_floor <= 32'h0000_0000;
    end else begin
      ctrl <= ctrl_d;
      ramp_floor <= ramp_en_w ? floor_q : 32'h0000_0000;
    end
  end

  // ==========================================
  // Divider and lock detector
  pcc_ref_divider u_div (
    .ref_clk(ref_clk),
    .rst(rst),
    .div_rst(div_reset),
    .div_en(cfg_q[DIV_EN_BIT]),
    .div_sel(cfg_q[DIV_SEL_LO +: 2]),
    .ref_tick(ref_tick)
  );

  pcc_lock_detect u_lock (
    .ref_clk(ref_clk),
    .rst(rst),
    .enable(cfg_q[LOCK_EN_BIT]),
    .in_window(win_s2_q),
    .ref_tick(ref_tick),
    .win_sel(cfg_q[LOCK_SEL_LO +: 2]),
    .locked(locked)
  );

  // ==========================================
  // Independent count of in-window ticks for the lock window check
  localparam logic [10:0] SEEN_MAX = 11'h7FF;
  wire logic [10:0] win_len_w = LOCK_BASE << cfg_q[LOCK_SEL_LO +: 2];
  logic [10:0] seen_q;

  always_ff @(posedge ref_clk) begin
    if (rst || !cfg_q[LOCK_EN_BIT] || !win_s2_q) begin
      seen_q <= 11'h000;
    end else if (ref_tick && seen_q != SEEN_MAX) begin
      seen_q <= seen_q + 11'h001;
    end
  end

  // Calibration start is a command, so no reset value may hold it
  if (CAL_RESET[CAL_EN_BIT]) begin : g_bad_cal_reset
    $error("calibration reset value must leave the start bit clear");
  end

  // ==========================================
  // Checks
  AST_DIV_RST: assert property (@(posedge ref_clk) disable iff (rst)
    div_rst_cmd |=> div_reset ##1 ref_tick)
    else $error("divider reset not applied");
  AST_DIV_BY8: assert property (@(posedge ref_clk) disable iff (rst)
    (ref_tick && cfg_q[DIV_EN_BIT] && cfg_q[DIV_SEL_LO +: 2] == 2'h3 && !req.wr
      && !div_reset && $past(cfg_q[DIV_EN_BIT]) && !$past(div_reset))
    |=> !ref_tick)
    else $error("divide by eight ticked too soon");
  AST_BYPASS: assert property (@(posedge ref_clk) disable iff (rst)
    !cfg_q[DIV_EN_BIT] |=> ref_tick)
    else $error("bypassed divider did not tick");
  AST_DOUBLER: assert property (@(posedge ref_clk) disable iff (rst)
    !(cfg_q[DBL_EN_BIT] && cfg_q[DBL_EDGE_BIT]) |=> !ctrl.doubler_on)
    else $error("doubler on without both bits");
  AST_PLL: assert property (@(posedge ref_clk) disable iff (rst)
    wr_cfg |=> ##1 (ctrl.pll_on == $past(req.wdata[PLL_EN_BIT], 2)))
    else $error("pll enable not followed");
  AST_MULT: assert property (@(posedge ref_clk) disable iff (rst)
    wr_cfg |=> ##1 (ctrl.mult == {$past(req.wdata[FBN_LO +: 8], 2), 1'b0}))
    else $error("multiplication not twice n");
  AST_N_RESET: assert property (@(posedge ref_clk)
    rst |=> fbn_w == FBN_RESET)
    else $error("feedback divider reset value wrong");
  AST_PUMP: assert property (@(posedge ref_clk) disable iff (rst)
    cfg_q[MAN_ICP_BIT] |=> ctrl.pump_current == $past(cfg_q[ICP_LO +: 3]))
    else $error("manual pump current not applied");
  AST_LOCK_OFF: assert property (@(posedge ref_clk) disable iff (rst)
    (!cfg_q[LOCK_EN_BIT] || !win_s2_q) |=> !locked)
    else $error("locked while disabled or out of window");
  AST_SYNC: assert property (@(posedge ref_clk) disable iff (rst)
    cal_q[AUX_PD_BIT] |=> !ctrl.sync_out_on && !ctrl.cal_clk_on)
    else $error("sync output not powered down");
  AST_CAL: assert property (@(posedge ref_clk) disable iff (rst)
    cal_cmd |=> cal_start)
    else $error("calibration start missing");
  AST_RAMP: assert property (@(posedge ref_clk) disable iff (rst)
    !ramp_en_w |=> ramp_floor == 32'h0000_0000)
    else $error("ramp floor visible while ramp off");
  AST_CAL_ONCE: assert property (@(posedge ref_clk) disable iff (rst)
    !cal_cmd |=> !cal_start)
    else $error("calibration start without command");
  AST_DIV_RST_ONCE: assert property (@(posedge ref_clk) disable iff (rst)
    !div_rst_cmd |=> !div_reset)
    else $error("divider reset without command");
  AST_DIV_SEL: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> ctrl.div_sel == $past(cfg_q[DIV_SEL_LO +: 2]))
    else $error("divider select not followed");
  AST_DIV_ACT: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> ctrl.div_active == $past(cfg_q[DIV_EN_BIT]))
    else $error("divider enable not followed");
  AST_DBL_ON: assert property (@(posedge ref_clk) disable iff (rst)
    (cfg_q[DBL_EN_BIT] && cfg_q[DBL_EDGE_BIT]) |=> ctrl.doubler_on)
    else $error("doubler off with both bits set");
  AST_PLL_NOW: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> ctrl.pll_on == $past(cfg_q[PLL_EN_BIT]))
    else $error("pll enable out of step");
  AST_MULT_NOW: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> ctrl.mult == {$past(fbn_w), 1'b0})
    else $error("multiplication out of step");
  AST_PUMP_AUTO: assert property (@(posedge ref_clk) disable iff (rst)
    !cfg_q[MAN_ICP_BIT] |=> ctrl.pump_current == $past(icp_s2_q))
    else $error("automatic pump current not applied");
  AST_PUMP_FLAG: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> ctrl.pump_manual == $past(cfg_q[MAN_ICP_BIT]))
    else $error("manual pump flag not followed");
  AST_LOCK_EN: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> ctrl.lock_det_on == $past(cfg_q[LOCK_EN_BIT]))
    else $error("lock detect enable not followed");
  AST_SYNC_ON: assert property (@(posedge ref_clk) disable iff (rst)
    !cal_q[AUX_PD_BIT] |=> ctrl.sync_out_on)
    else $error("sync output off while powered");
  AST_CALCLK_ON: assert property (@(posedge ref_clk) disable iff (rst)
    (!cal_q[CALCLK_PD_BIT] && !cal_q[AUX_PD_BIT]) |=> ctrl.cal_clk_on)
    else $error("calibration clock off while powered");
  AST_CALCLK_PD: assert property (@(posedge ref_clk) disable iff (rst)
    cal_q[CALCLK_PD_BIT] |=> !ctrl.cal_clk_on)
    else $error("calibration clock runs while powered down");
  AST_RAMP_ON: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> ctrl.ramp_on == $past(ramp_en_w))
    else $error("ramp enable not followed");
  AST_RAMP_PASS: assert property (@(posedge ref_clk) disable iff (rst)
    ramp_en_w |=> ramp_floor == $past(floor_q))
    else $error("ramp floor not passed while ramp on");
  AST_RD_FLOOR: assert property (@(posedge ref_clk) disable iff (rst)
    (req.rd && req.addr == ADDR_RAMP_FLOOR) |=> rdata == $past(floor_q))
    else $error("ramp floor read back wrong");
  AST_CAL_RD: assert property (@(posedge ref_clk) disable iff (rst)
    (req.rd && req.addr == ADDR_CAL) |=> !rdata[CAL_EN_BIT])
    else $error("calibration start read back as one");
  AST_LOCK_READ: assert property (@(posedge ref_clk) disable iff (rst)
    (req.rd && req.addr == ADDR_STATUS) |=> rdata[LOCK_STAT_BIT] == $past(locked))
    else $error("lock status read back wrong");
  AST_LOCK_STATUS_ONLY: assert property (@(posedge ref_clk) disable iff (rst)
    (req.rd && req.addr == ADDR_STATUS) |=> (rdata & ~(32'h1 << LOCK_STAT_BIT)) == 32'h0)
    else $error("status read shows bits beside lock");
  AST_LOCK_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
    (locked && cfg_q[LOCK_EN_BIT] && win_s2_q) |=> locked)
    else $error("lock dropped while in window");
  AST_LOCK_RISE: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(locked) |-> $past(ref_tick))
    else $error("lock rose without a reference tick");
  AST_LOCK_WINDOW: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(locked) |-> seen_q >= $past(win_len_w))
    else $error("lock rose before the window count");
  AST_CFG_KEEP: assert property (@(posedge ref_clk) disable iff (rst)
    !wr_cfg |=> $stable(cfg_q))
    else $error("configuration changed without a write");
  AST_CTRL2_KEEP: assert property (@(posedge ref_clk) disable iff (rst)
    !wr_ctrl2 |=> $stable(ctrl2_q))
    else $error("second control register changed without a write");
endmodule // pcc_clock_config
`default_nettype wire

// ===== testbench/testbench.sv
// Self-checking bench for the clock configuration registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pcc_pkg::*;
  // ==========================================
  // Signals and clock
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  pcc_req_t req = '0;
  logic phase_in_window_pin = 1'b0;
  logic [2:0] auto_pump_current_pin = 3'h5;
  logic [31:0] rdata;
  logic rd_valid;
  pcc_ctrl_t ctrl;
  logic ref_tick;
  logic locked;
  logic div_reset;
  logic cal_start;
  logic [31:0] ramp_floor;
  logic [31:0] rd_word;
  int n_mismatch = 0;
  int compares = 0;
  int n_tick = 0;
  int n_div = 0;
  int n_cal = 0;

  always #5 ref_clk = ~ref_clk;

  // Pulses are counted at every edge so none is missed between task steps
  always @(posedge ref_clk) begin
    n_tick = n_tick + ref_tick;
    n_div = n_div + div_reset;
    n_cal = n_cal + cal_start;
  end

  pcc_clock_config u_dut (
    .ref_clk(ref_clk), .rst(rst), .req(req), .rdata(rdata), .rd_valid(rd_valid),
    .phase_in_window_pin(phase_in_window_pin),
    .auto_pump_current_pin(auto_pump_current_pin), .ctrl(ctrl), .ref_tick(ref_tick),
    .locked(locked), .div_reset(div_reset), .cal_start(cal_start), .ramp_floor(ramp_floor)
  );

  // ==========================================
  // Shared tasks
  task automatic give_verdict();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // The trailing idle cycle keeps a strobe from being set twice in one time step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    req.addr = a;
    req.wdata = d;
    req.wr = 1'b1;
    step(1);
    req.wr = 1'b0;
    step(1);
  endtask

  task automatic rd(input logic [7:0] a);
    req.addr = a;
    req.rd = 1'b1;
    step(1);
    chk(32'(rd_valid), 32'h1);
    rd_word = rdata;
    req.rd = 1'b0;
    step(1);
  endtask

  task automatic wait_lock(input logic lvl, input int bound);
    int i;
    for (i = 0; i < bound && locked !== lvl; i++) begin
      step(1);
    end
    chk(32'(locked), 32'(lvl));
    if (locked !== lvl) begin
      give_verdict();
    end
  endtask

  // ==========================================
  // Scenarios
  task automatic t_reset();
    rd(ADDR_CTRL2);
    chk(rd_word, 32'h0000_0800);
    rd(ADDR_PLL_CFG);
    chk(rd_word, 32'h0000_1900);
    rd(ADDR_RAMP_FLOOR);
    chk(rd_word, 32'h0);
    chk(32'(ctrl.mult), 32'h32);
    chk(32'(ctrl.ramp_on), 32'h0);
    chk(32'(locked), 32'h0);
  endtask

  // Lowest legal N and a doubler with only one of its two bits set
  task automatic t_fields();
    wr(ADDR_PLL_CFG, 32'h001E_0A54);
    step(2);
    chk(32'(ctrl.div_active), 32'h1);
    chk(32'(ctrl.div_sel), 32'h1);
    chk(32'(ctrl.doubler_on), 32'h0);
    chk(32'(ctrl.pll_on), 32'h1);
    chk(32'(ctrl.mult), 32'h14);
    chk(32'(ctrl.pump_manual), 32'h1);
    chk(32'(ctrl.pump_current), 32'h2);
    chk(32'(ctrl.lock_det_on), 32'h1);
    wr(ADDR_STATUS, 32'h0100_0000);
    chk(32'(ctrl.pll_on), 32'h1);
    wr(ADDR_PLL_CFG, 32'h0009_FF00);
    step(4);
    chk(32'(ctrl.div_active), 32'h0);
    chk(32'(ctrl.doubler_on), 32'h1);
    chk(32'(ctrl.pll_on), 32'h0);
    chk(32'(ctrl.mult), 32'h1FE);
    chk(32'(ctrl.pump_current), 32'h5);
    chk(32'(ctrl.lock_det_on), 32'h0);
  endtask

  // Windows of 32 cycles hold a whole number of periods at every ratio
  task automatic t_divider();
    n_div = 0;
    for (int k = 0; k < 5; k++) begin
      wr(ADDR_PLL_CFG, (k < 4) ? (32'h0002_0000 | (k << 20)) : 32'h0030_0000);
      step(4);
      n_tick = 0;
      step(32);
      chk(32'(n_tick), (k < 4) ? 32'(32 >> k) : 32'h20);
    end
    chk(32'(n_div), 32'h0);
    wr(ADDR_PLL_CFG, 32'h0042_0000);
    step(2);
    chk(32'(n_div), 32'h1);
  endtask

  task automatic t_lock();
    phase_in_window_pin = 1'b1;
    step(200);
    chk(32'(locked), 32'h0);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_PLL_CFG, 32'h0);
      step(2);
      wr(ADDR_PLL_CFG, 32'h4 | k);
      step((128 << k) - 10);
      chk(32'(locked), 32'h0);
      wait_lock(1'b1, 30);
    end
    rd(ADDR_STATUS);
    chk(rd_word, 32'h0100_0000);
    phase_in_window_pin = 1'b0;
    wait_lock(1'b0, 6);
  endtask

  task automatic t_cal();
    logic [31:0] v [4] = '{32'h0, 32'h0200_0000, 32'h0400_0000, 32'h0600_0000};
    n_cal = 0;
    wr(ADDR_CAL, 32'h0100_0000);
    step(2);
    chk(32'(n_cal), 32'h1);
    rd(ADDR_CAL);
    chk(rd_word, 32'h0);
    foreach (v[i]) begin
      wr(ADDR_CAL, v[i]);
      step(2);
      chk(32'(ctrl.sync_out_on), 32'(!v[i][26]));
      chk(32'(ctrl.cal_clk_on), 32'(v[i][26:25] == 2'b00));
    end
    chk(32'(n_cal), 32'h1);
  endtask

  task automatic t_ramp();
    wr(ADDR_RAMP_FLOOR, 32'hA5C3_0F1E);
    step(2);
    chk(ramp_floor, 32'h0);
    rd(ADDR_RAMP_FLOOR);
    chk(rd_word, 32'hA5C3_0F1E);
    wr(ADDR_CTRL2, 32'h0008_0800);
    step(2);
    chk(32'(ctrl.ramp_on), 32'h1);
    chk(ramp_floor, 32'hA5C3_0F1E);
    wr(8'h2A, 32'hFFFF_FFFF);
    rd(8'h2A);
    chk(rd_word, 32'h0);
    wr(ADDR_STATUS, 32'hFFFF_FFFF);
    rd(ADDR_STATUS);
    chk(rd_word, 32'h0);
  endtask

  // ==========================================
  // Main sequence
  initial begin
    step(4);
    rst = 1'b0;
    step(2);
    t_reset();
    t_fields();
    t_divider();
    t_lock();
    t_cal();
    t_ramp();
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
